// file: smd_host_model.sv
`timescale 1ns/1ps
module smd_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] cfg_three,
  input wire logic [7:0] cfg_one,
  input wire logic [31:0] rdata,
  output logic busy,
  output logic [7:0] addr,
  output logic rd_stb,
  output logic [2:0] index
);
  // Quiet bus until the first walk
  initial begin
    busy = 1'b0;
    addr = 8'h00;
    rd_stb = 1'b0;
    index = 3'h0;
  end

  // One parameter read; answer taken only in the cycle after the strobe
  task automatic fetch(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : fetch

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor walk, folding one selected bit per descriptor into the index
  initial begin
    logic [31:0] cmd;
    logic [31:0] radr;
    logic [7:0] cfg;
    logic [7:0] a;
    logic [2:0] idx;
    forever begin
      @(posedge mclk iff go);
      busy <= 1'b1;
      idx = 3'h0;
      a = 8'h48;
      for (int i = 0; i < 3; i++) begin
        fetch(a, cmd);
        fetch(a + 8'h04, radr);
        // variable width and latency, so own settings apply
        cfg = (radr == 32'h0000_0004) ? cfg_three : cfg_one;
        cfg = (cmd[15:8] == 8'h65) ? cfg : 8'h00;
        // mask the byte, first descriptor most significant
        idx = {idx[1:0], |(cfg & cmd[31:24])};
        a = a + 8'h08;
        if (cmd[0]) break;
      end
      index <= idx;
      busy <= 1'b0;
    end
  end
endmodule : smd_host_model

// file: smd_pkg.sv
package smd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the plain register port
  localparam logic [7:0] CTRL_OFF = 8'h40;
  localparam logic [7:0] STAT_OFF = 8'h44;
  localparam logic [7:0] TABLE_BASE_OFF = 8'h48;
  localparam logic [7:0] DET1_CMD_OFF = 8'h48;
  localparam logic [7:0] DET1_ADDR_OFF = 8'h4C;
  localparam logic [7:0] DET2_CMD_OFF = 8'h50;
  localparam logic [7:0] DET2_ADDR_OFF = 8'h54;
  localparam logic [7:0] DET3_CMD_OFF = 8'h58;
  localparam logic [7:0] DET3_ADDR_OFF = 8'h5C;
  localparam logic [7:0] TABLE_BYTES = 8'h18;
  localparam int TABLE_WORDS = 6;

  // Control register fields and values after reset
  localparam int CTRL_BYTE_MODE_BIT = 0;
  localparam logic CTRL_BYTE_MODE_RST = 1'b0;
  localparam logic [15:0] READ_COUNT_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside a detection command word
  localparam int MASK_LSB = 24;
  localparam int ALEN_LSB = 22;
  localparam int RFU2_LSB = 20;
  localparam int LAT_LSB = 16;
  localparam int INSTR_LSB = 8;
  localparam int RFU6_LSB = 2;
  localparam int DESC_KIND_BIT = 1;
  localparam int END_FLAG_BIT = 0;

  // Field values
  localparam logic [1:0] ALEN_VARIABLE = 2'h3;
  localparam logic [1:0] RFU2_ONES = 2'h3;
  localparam logic [3:0] LAT_VARIABLE = 4'hF;
  localparam logic [7:0] READ_ANY_REG_INSTR = 8'h65;
  localparam logic [5:0] RFU6_ONES = 6'h3F;
  localparam logic DESC_KIND_COMMAND = 1'b0;
  localparam logic END_SET = 1'b1;
  localparam logic END_CLEAR = 1'b0;

  // Masks and target register addresses of the three detections
  localparam logic [7:0] DET1_MASK = 8'h08;
  localparam logic [7:0] DET2_MASK = 8'h04;
  localparam logic [7:0] DET3_MASK = 8'h02;
  localparam logic [31:0] NONVOLATILE_CONFIG_THREE_ADDR = 32'h0000_0004;
  localparam logic [31:0] NONVOLATILE_CONFIG_ONE_ADDR = 32'h0000_0002;

  typedef struct packed {
    logic [31:0] rdata;
    logic byte_mode;
    logic [15:0] read_count;
  } smd_state_t;

  // Assemble one detection command word from its mask and end flag
  function automatic logic [31:0] smd_det_word(input logic [7:0] mask, input logic last);
    smd_det_word = {mask, ALEN_VARIABLE, RFU2_ONES, LAT_VARIABLE, READ_ANY_REG_INSTR,
                    RFU6_ONES, DESC_KIND_COMMAND, last};
  endfunction : smd_det_word

endpackage : smd_pkg

// file: smd_sector_map_detect.sv
// Behaviour
// R1: First descriptor address word points at nonvolatile_config_three, low byte first.
// R2: Second descriptor mask selects only bit 2, param_sector_top_select.
// R3: Every descriptor names read-any-register as its detection instruction.
// R4: Address length field coded variable, host uses its current address width.
// R5: Latency field coded variable, host inserts its configured dummy cycles.
// R6: Second descriptor address word points at nonvolatile_config_one.
// R7: Third descriptor mask selects only bit 1, uniform_block_size_select.
// R8: Only the third descriptor sets the end flag; host stops after it.
// R9: Every detection descriptor clears bit 1, marking a command descriptor.
// R10: Reserved two-bit and six-bit fields of the first word read as ones.
// R11: Top byte of each first word carries the read data mask.
// R12: Third descriptor address word points at nonvolatile_config_three again.
// R13: Host concatenates selected bits, first descriptor most significant, into index.
// R14: Table bytes are returned on any read, independent of other state; here the byte mode still selects a byte or a whole word.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps

module smd_sector_map_detect #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the map reaches byte 5Fh, so seven address bits at least
  if (ADDR_W < 7) begin : g_addr_check
    $error("smd_sector_map_detect: ADDR_W must be at least 7");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Constant descriptor table, one entry per word
  // R3 read-any-register
  // R4 variable address length
  // R5 variable latency
  // R9 command descriptor kind
  // R10 reserved fields ones
  // R11 mask in top byte
  function automatic logic [31:0] smd_table_word(input logic [2:0] idx);
    case (idx)
      3'h0: smd_table_word = smd_pkg::smd_det_word(smd_pkg::DET1_MASK, smd_pkg::END_CLEAR);
      // R1 first address word
      3'h1: smd_table_word = smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR;
      // R2 bit two mask
      3'h2: smd_table_word = smd_pkg::smd_det_word(smd_pkg::DET2_MASK, smd_pkg::END_CLEAR);
      // R6 second address word
      3'h3: smd_table_word = smd_pkg::NONVOLATILE_CONFIG_ONE_ADDR;
      // R7 R8 bit one mask, end flag
      3'h4: smd_table_word = smd_pkg::smd_det_word(smd_pkg::DET3_MASK, smd_pkg::END_SET);
      // R12 third address word
      3'h5: smd_table_word = smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR;
      default: smd_table_word = 32'h0000_0000;
    endcase
  endfunction : smd_table_word

  ////////////////////////////////////////////////////////////////////////////
  // State
  smd_pkg::smd_state_t cur;
  smd_pkg::smd_state_t next_cur;
  logic [ADDR_W-1:0] table_off;
  logic in_table;
  logic [31:0] sel_word;
  logic [7:0] sel_byte;

  // Offset within the table; the compare keeps wrap-around below the base out
  assign table_off = addr - ADDR_W'(smd_pkg::TABLE_BASE_OFF);
  assign in_table = (addr >= ADDR_W'(smd_pkg::TABLE_BASE_OFF)) &&
                    (table_off < ADDR_W'(smd_pkg::TABLE_BYTES));
  assign sel_word = smd_table_word(table_off[4:2]);
  assign sel_byte = sel_word[8*table_off[1:0] +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: decode, read data, control and read counter
  // R14 table reads ignore all state but the byte mode
  always_comb begin
    next_cur = cur;
    // Read data stand one cycle only, zero otherwise
    next_cur.rdata = 32'h0000_0000;
    if (rd_stb) begin
      if (in_table) begin
        // Byte mode mirrors the byte-wide parameter area; word mode returns dwords
        if (cur.byte_mode) begin
          next_cur.rdata = {24'h000000, sel_byte};
        end else begin
          next_cur.rdata = sel_word;
        end
        next_cur.read_count = cur.read_count + 16'h0001;
      end else if (addr == ADDR_W'(smd_pkg::CTRL_OFF)) begin
        next_cur.rdata = {31'h0000_0000, cur.byte_mode};
      end else if (addr == ADDR_W'(smd_pkg::STAT_OFF)) begin
        next_cur.rdata = {16'h0000, cur.read_count};
      end else begin
        // Unmapped address reads as zero
        next_cur.rdata = 32'h0000_0000;
      end
    end
    if (wr_stb) begin
      // Table is constant; writes to it are dropped silently
      if (addr == ADDR_W'(smd_pkg::CTRL_OFF)) begin
        next_cur.byte_mode = wdata[smd_pkg::CTRL_BYTE_MODE_BIT];
      end else if (addr == ADDR_W'(smd_pkg::STAT_OFF)) begin
        next_cur.read_count = smd_pkg::READ_COUNT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register, reset by srst whatever the clock enable, otherwise frozen while it is low
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur.rdata <= smd_pkg::RDATA_RST;
      cur.byte_mode <= smd_pkg::CTRL_BYTE_MODE_RST;
      cur.read_count <= smd_pkg::READ_COUNT_RST;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign rdata = cur.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, word and byte mode reads of each table word
  // R1 first address word
  a_det1_addr_word: assert property (@(posedge mclk) disable iff (srst) // R1
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET1_ADDR_OFF))
    |=> (rdata == smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR))
    else $error("first detection address word wrong");

  // R1 least significant byte first
  a_det1_addr_byte: assert property (@(posedge mclk) disable iff (srst) // R1
    (ce && rd_stb && cur.byte_mode && addr == ADDR_W'(smd_pkg::DET1_ADDR_OFF))
    |=> (rdata == {24'h000000, smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR[7:0]}))
    else $error("first detection address low byte not first");

  // R2 bit two mask
  a_det2_mask_sel: assert property (@(posedge mclk) disable iff (srst) // R2
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET2_CMD_OFF))
    |=> (rdata[31:24] == smd_pkg::DET2_MASK && $onehot(rdata[31:24])))
    else $error("second detection mask wrong");

  // R3 instruction in every command word
  a_instr_field: assert property (@(posedge mclk) disable iff (srst) // R3
    (ce && rd_stb && !cur.byte_mode && in_table && table_off[2:0] == 3'h0)
    |=> (rdata[15:8] == smd_pkg::READ_ANY_REG_INSTR))
    else $error("detection instruction wrong");

  // R4 R5 variable length and latency
  a_var_fields: assert property (@(posedge mclk) disable iff (srst) // R4 R5
    (ce && rd_stb && !cur.byte_mode && in_table && table_off[2:0] == 3'h0)
    |=> (rdata[23:22] == smd_pkg::ALEN_VARIABLE && rdata[19:16] == smd_pkg::LAT_VARIABLE))
    else $error("address length or latency not variable");

  // R6 second address word
  a_det2_addr_word: assert property (@(posedge mclk) disable iff (srst) // R6
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET2_ADDR_OFF))
    |=> (rdata == smd_pkg::NONVOLATILE_CONFIG_ONE_ADDR))
    else $error("second detection address word wrong");

  // R7 bit one mask
  a_det3_mask_sel: assert property (@(posedge mclk) disable iff (srst) // R7
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET3_CMD_OFF))
    |=> (rdata[31:24] == smd_pkg::DET3_MASK && $onehot(rdata[31:24])))
    else $error("third detection mask wrong");

  // R8 end flag set on the third
  a_end_flag_last: assert property (@(posedge mclk) disable iff (srst) // R8
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET3_CMD_OFF))
    |=> (rdata[smd_pkg::END_FLAG_BIT] == smd_pkg::END_SET))
    else $error("end flag missing on third descriptor");

  // R8 earlier flags clear
  a_end_flag_clear: assert property (@(posedge mclk) disable iff (srst) // R8
    (ce && rd_stb && !cur.byte_mode && in_table && table_off[2:0] == 3'h0 &&
     addr != ADDR_W'(smd_pkg::DET3_CMD_OFF))
    |=> (rdata[smd_pkg::END_FLAG_BIT] == smd_pkg::END_CLEAR))
    else $error("end flag set on an earlier descriptor");

  // R9 R10 kind bit and reserved fields
  a_kind_rfu: assert property (@(posedge mclk) disable iff (srst) // R9 R10
    (ce && rd_stb && !cur.byte_mode && in_table && table_off[2:0] == 3'h0)
    |=> (rdata[1] == smd_pkg::DESC_KIND_COMMAND && rdata[21:20] == 2'h3 && rdata[7:2] == 6'h3F))
    else $error("kind bit or reserved fields wrong");

  // R11 mask byte read alone in byte mode
  a_mask_top_byte: assert property (@(posedge mclk) disable iff (srst) // R11
    (ce && rd_stb && cur.byte_mode && addr == ADDR_W'(smd_pkg::DET1_CMD_OFF + 8'h03))
    |=> (rdata == {24'h000000, smd_pkg::DET1_MASK}))
    else $error("mask not in top byte");

  // R12 third address word
  a_det3_addr_word: assert property (@(posedge mclk) disable iff (srst) // R12
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET3_ADDR_OFF))
    |=> (rdata == smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR))
    else $error("third detection address word wrong");

  // R14 same answer twice on back-to-back reads, address and mode unchanged
  a_read_stable: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && in_table) ##1 (ce && rd_stb && $stable(addr) && $stable(cur.byte_mode))
    |=> (rdata == $past(rdata)))
    else $error("table read not constant");

  // Read data last one cycle only
  a_rdata_pulse: assert property (@(posedge mclk) disable iff (srst)
    (ce && !rd_stb) |=> (rdata == 32'h0000_0000))
    else $error("read data held past its cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, single fields of the table
  // R11 first mask top byte
  a_det1_mask_sel: assert property (@(posedge mclk) disable iff (srst) // R11
    (ce && rd_stb && !cur.byte_mode && addr == ADDR_W'(smd_pkg::DET1_CMD_OFF))
    |=> (rdata[31:24] == smd_pkg::DET1_MASK))
    else $error("first detection mask wrong");

  // R3 instruction byte
  a_instr_byte: assert property (@(posedge mclk) disable iff (srst) // R3
    (ce && rd_stb && cur.byte_mode && in_table && table_off[2:0] == 3'h1)
    |=> (rdata == {24'h000000, smd_pkg::READ_ANY_REG_INSTR}))
    else $error("instruction byte wrong");

  // R4 R5 variable fields byte
  a_var_byte: assert property (@(posedge mclk) disable iff (srst) // R4 R5
    (ce && rd_stb && cur.byte_mode && in_table && table_off[2:0] == 3'h2)
    |=> (rdata == {24'h000000, smd_pkg::ALEN_VARIABLE, smd_pkg::RFU2_ONES, smd_pkg::LAT_VARIABLE}))
    else $error("length or latency byte wrong");

  // R9 R10 kind and reserved
  a_low_byte: assert property (@(posedge mclk) disable iff (srst) // R9 R10
    (ce && rd_stb && cur.byte_mode && in_table && table_off[2:0] == 3'h0)
    |=> (rdata[7:2] == smd_pkg::RFU6_ONES && rdata[1] == smd_pkg::DESC_KIND_COMMAND))
    else $error("kind or reserved byte wrong");

  // R11 one-hot mask byte
  a_mask_byte: assert property (@(posedge mclk) disable iff (srst) // R11
    (ce && rd_stb && cur.byte_mode && in_table && table_off[2:0] == 3'h3)
    |=> (rdata[31:8] == 24'h000000 && $onehot(rdata[7:0])))
    else $error("mask byte not one-hot");

  // R8 end flag byte
  a_det3_end_byte: assert property (@(posedge mclk) disable iff (srst) // R8
    (ce && rd_stb && cur.byte_mode && addr == ADDR_W'(smd_pkg::DET3_CMD_OFF))
    |=> (rdata == {24'h000000, smd_pkg::RFU6_ONES, smd_pkg::DESC_KIND_COMMAND, smd_pkg::END_SET}))
    else $error("third descriptor low byte wrong");

  // R1 R6 R12 upper address bytes
  a_addr_high_zero: assert property (@(posedge mclk) disable iff (srst) // R1 R6 R12
    (ce && rd_stb && cur.byte_mode && in_table && table_off[2] &&
     table_off[1:0] != 2'h0)
    |=> (rdata == 32'h0000_0000))
    else $error("upper address byte not zero");

  // R6 second address byte
  a_det2_addr_byte: assert property (@(posedge mclk) disable iff (srst) // R6
    (ce && rd_stb && cur.byte_mode && addr == ADDR_W'(smd_pkg::DET2_ADDR_OFF))
    |=> (rdata == {24'h000000, smd_pkg::NONVOLATILE_CONFIG_ONE_ADDR[7:0]}))
    else $error("second detection address byte wrong");

  // R12 third address byte
  a_det3_addr_byte: assert property (@(posedge mclk) disable iff (srst) // R12
    (ce && rd_stb && cur.byte_mode && addr == ADDR_W'(smd_pkg::DET3_ADDR_OFF))
    |=> (rdata == {24'h000000, smd_pkg::NONVOLATILE_CONFIG_THREE_ADDR[7:0]}))
    else $error("third detection address byte wrong");

  // R14 upper bytes zero
  a_byte_upper_zero: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && cur.byte_mode && in_table)
    |=> (rdata[31:8] == 24'h000000))
    else $error("byte read carries upper bits");

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, control, counter, reset and clock enable
  // R14 control readback
  a_ctrl_read: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && addr == ADDR_W'(smd_pkg::CTRL_OFF))
    |=> (rdata[31:1] == 31'h0000_0000 && rdata[0] == $past(cur.byte_mode)))
    else $error("control readback wrong");

  // R14 counter readback
  a_stat_read: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && addr == ADDR_W'(smd_pkg::STAT_OFF))
    |=> (rdata == {16'h0000, $past(cur.read_count)}))
    else $error("counter readback wrong");

  // R14 unmapped reads zero
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && !in_table && addr != ADDR_W'(smd_pkg::CTRL_OFF) &&
     addr != ADDR_W'(smd_pkg::STAT_OFF))
    |=> (rdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // Byte mode set by write
  a_ctrl_write_set: assert property (@(posedge mclk) disable iff (srst)
    (ce && wr_stb && addr == ADDR_W'(smd_pkg::CTRL_OFF) && wdata[smd_pkg::CTRL_BYTE_MODE_BIT])
    |=> cur.byte_mode)
    else $error("byte mode not set by write");

  // Byte mode cleared by write
  a_ctrl_write_clear: assert property (@(posedge mclk) disable iff (srst)
    (ce && wr_stb && addr == ADDR_W'(smd_pkg::CTRL_OFF) &&
     !wdata[smd_pkg::CTRL_BYTE_MODE_BIT])
    |=> !cur.byte_mode)
    else $error("byte mode not cleared by write");

  // Counter cleared by write
  a_count_clear: assert property (@(posedge mclk) disable iff (srst)
    (ce && wr_stb && addr == ADDR_W'(smd_pkg::STAT_OFF))
    |=> (cur.read_count == smd_pkg::READ_COUNT_RST))
    else $error("read counter not cleared");

  // R14 counter counts table reads
  a_count_step: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && rd_stb && in_table)
    |=> (cur.read_count == $past(cur.read_count) + 16'h0001))
    else $error("read counter did not step");

  // R14 table writes dropped
  a_table_write_drop: assert property (@(posedge mclk) disable iff (srst) // R14
    (ce && wr_stb && !rd_stb && in_table)
    |=> ($stable(cur.byte_mode) && $stable(cur.read_count)))
    else $error("table write changed state");

  // Clock enable low freezes all
  a_ce_freeze: assert property (@(posedge mclk) disable iff (srst)
    (!ce)
    |=> ($stable(rdata) && $stable(cur.byte_mode) && $stable(cur.read_count)))
    else $error("state moved with clock enable low");

  // Reset values
  a_reset_state: assert property (@(posedge mclk)
    srst |=> (rdata == smd_pkg::RDATA_RST && cur.byte_mode == smd_pkg::CTRL_BYTE_MODE_RST
    && cur.read_count == smd_pkg::READ_COUNT_RST))
    else $error("state not cleared by reset");

  // Answers only from a read or a freeze
  a_rdata_source: assert property (@(posedge mclk) disable iff (srst)
    (rdata != 32'h0000_0000)
    |-> ($past(rd_stb) || !$past(ce)))
    else $error("read data without a read");

endmodule : smd_sector_map_detect

// file: smd_sector_map_detect_tb_top.sv
`timescale 1ns/1ps
module smd_sector_map_detect_tb_top;
  logic mclk, srst, ce, wr_stb, b_rd, go, h_busy, h_rd;
  logic [7:0] b_addr, h_addr, cfg3, cfg1;
  logic [31:0] wdata, rdata, got;
  logic [2:0] index;
  logic [31:0] tbl [6];
  int errors, checked;

  smd_sector_map_detect dut (.mclk(mclk), .srst(srst), .ce(ce),
    .addr(h_busy ? h_addr : b_addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(b_rd | h_rd), .rdata(rdata));
  smd_host_model host (.mclk(mclk), .go(go), .cfg_three(cfg3), .cfg_one(cfg1),
    .rdata(rdata), .busy(h_busy), .addr(h_addr), .rd_stb(h_rd), .index(index));

  // Free-running clock, 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    b_addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    b_addr <= a;
    b_rd <= 1'b1;
    @(posedge mclk);
    b_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Host walk with given configuration bytes, index compared to selected bits
  task automatic walk(input logic [7:0] c3, input logic [7:0] c1);
    cfg3 <= c3;
    cfg1 <= c1;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 60 && h_busy; i++) @(posedge mclk);
    #1 chk({29'h0, index}, {29'h0, c3[3], c1[2], c3[1]});
  endtask : walk

  // Hangs are cut well beyond the expected run
  initial begin
    #20000;
    errors++;
    print_verdict();
  end

  initial begin
    {srst, ce, wr_stb, b_rd, go} = 5'h10;
    {b_addr, wdata, cfg3, cfg1} = '0;
    // command words built field by field
    for (int i = 0; i < 3; i++)
      tbl[2*i] = {8'h08 >> i, 2'h3, 2'h3, 4'hF, 8'h65, 6'h3F, 1'b0, i == 2};
    tbl[1] = 32'h0000_0004;
    tbl[3] = 32'h0000_0002;
    tbl[5] = 32'h0000_0004;
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h40, got); chk(got, 32'h0000_0000);
    // every table word, then rdata drops
    for (int i = 0; i < 6; i++) begin
      rd(8'h48 + 8'(4 * i), got); chk(got, tbl[i]);
    end
    @(posedge mclk); #1 chk(rdata, 32'h0000_0000);
    rd(8'h4E, got); chk(got, tbl[1]);
    rd(8'h80, got); chk(got, 32'h0000_0000);
    // Writes into the table leave it untouched
    wr(8'h4C, 32'hFFFF_FFFF);
    rd(8'h4C, got); chk(got, tbl[1]);
    // Clock enable low: strobe ignored, last answer frozen in place
    @(posedge mclk);
    b_addr <= 8'h58;
    b_rd <= 1'b1;
    @(posedge mclk);
    b_rd <= 1'b0;
    ce <= 1'b0;
    rd(8'h48, got); chk(got, tbl[4]);
    @(posedge mclk);
    ce <= 1'b1;
    // Read counter: cleared by a write, then two table reads
    wr(8'h44, 32'h0000_0000);
    rd(8'h50, got);
    rd(8'h58, got);
    rd(8'h44, got); chk(got, 32'h0000_0002);
    // byte order, low byte at the lowest offset
    wr(8'h40, 32'h0000_0001);
    for (int b = 0; b < 24; b++) begin
      rd(8'h48 + 8'(b), got); chk(got, {24'h0, 8'(tbl[b / 4] >> (8 * (b % 4)))});
    end
    wr(8'h40, 32'h0000_0000);
    rd(8'h40, got); chk(got, 32'h0000_0000);
    // Back-to-back reads of one word, strobe held over two edges
    @(posedge mclk);
    b_addr <= 8'h54;
    b_rd <= 1'b1;
    @(posedge mclk);
    #1 chk(rdata, tbl[3]);
    @(posedge mclk);
    b_rd <= 1'b0;
    #1 chk(rdata, tbl[3]);
    // Reset in mid-run drops byte mode and clears the read counter
    wr(8'h40, 32'h0000_0001);
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd(8'h44, got); chk(got, 32'h0000_0000);
    rd(8'h40, got); chk(got, 32'h0000_0000);
    walk(8'h0A, 8'h04);
    walk(8'h08, 8'h00);
    walk(8'h02, 8'h00);
    walk(8'h00, 8'hFB);
    print_verdict();
  end
endmodule : smd_sector_map_detect_tb_top
